// >>> pin_xbar_pkg.sv
// Purpose: Shared constants and carrier types for the priority pin crossbar.
// Assumes: Four lower ports and four upper ports of eight pins each.
// Notes:   Signal codes give the fixed priority order, lowest code first.
package pin_xbar_pkg;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int PORT_W          = 8;
  localparam int NUM_LOWER_PORTS = 4;
  localparam int NUM_UPPER_PORTS = 4;
  localparam int NUM_PINS        = PORT_W * NUM_LOWER_PORTS;
  localparam int NUM_UPPER_PINS  = PORT_W * NUM_UPPER_PORTS;
  localparam int NUM_SIGS        = 11;
  localparam int SIG_W           = 4;

  // ******************************************************************
  // Peripheral signal codes in priority order
  // ******************************************************************
  localparam logic [SIG_W-1:0] SIG_TX0  = 4'h0;
  localparam logic [SIG_W-1:0] SIG_RX0  = 4'h1;
  localparam logic [SIG_W-1:0] SIG_SDA  = 4'h2;
  localparam logic [SIG_W-1:0] SIG_SCL  = 4'h3;
  localparam logic [SIG_W-1:0] SIG_SCK  = 4'h4;
  localparam logic [SIG_W-1:0] SIG_MISO = 4'h5;
  localparam logic [SIG_W-1:0] SIG_MOSI = 4'h6;
  localparam logic [SIG_W-1:0] SIG_NSS  = 4'h7;
  localparam logic [SIG_W-1:0] SIG_TX1  = 4'h8;
  localparam logic [SIG_W-1:0] SIG_RX1  = 4'h9;
  localparam logic [SIG_W-1:0] SIG_CNV  = 4'hA;
  localparam logic [SIG_W-1:0] SIG_NONE = 4'hF;

  // ******************************************************************
  // Port selection and reset values
  // ******************************************************************
  localparam logic [2:0]            FIRST_UPPER_PORT = 3'h4;
  localparam logic [NUM_PINS-1:0]   LATCH_RESET      = 32'hFFFFFFFF;
  localparam logic [NUM_PINS-1:0]   OUT_MODE_RESET   = 32'h00000000;
  localparam logic [NUM_PINS-1:0]   IN_MODE_RESET    = 32'hFFFFFFFF;
  localparam logic [PORT_W-1:0]     RD_DATA_RESET    = 8'h00;

  // Crossbar and pin configuration carried as one word.
  typedef struct packed {
    logic                crossbar_global_enable;
    logic                global_pullup_disable;
    logic                first_serial_port_pin_enable;
    logic                smbus_pin_enable;
    logic                spi_pin_enable;
    logic                spi_four_wire;
    logic                second_serial_port_pin_enable;
    logic                converter_b_start_enable;
    logic                first_serial_mode0;
    logic                second_serial_mode0;
    logic [NUM_PINS-1:0] port_output_mode_reg;
    logic [NUM_PINS-1:0] port_input_mode_reg;
  } xbar_cfg_t;

  localparam xbar_cfg_t CFG_RESET = '{
    crossbar_global_enable:        1'b0,
    global_pullup_disable:         1'b0,
    first_serial_port_pin_enable:  1'b0,
    smbus_pin_enable:              1'b0,
    spi_pin_enable:                1'b0,
    spi_four_wire:                 1'b0,
    second_serial_port_pin_enable: 1'b0,
    converter_b_start_enable:      1'b0,
    first_serial_mode0:            1'b0,
    second_serial_mode0:           1'b0,
    port_output_mode_reg:          OUT_MODE_RESET,
    port_input_mode_reg:           IN_MODE_RESET
  };

endpackage

// >>> pin_sync.sv
// Purpose: Three-stage synchroniser for pin levels with agreement filter.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   A bit changes only once the second and third stages agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int         W         = 32,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ******************************************************************
  // Stages
  // ******************************************************************
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // The filtered level follows only bits on which stages two and three agree.
  always_comb begin
    q_nxt = (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
  end

  // Registers the three stages and the filtered level.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r  <= RESET_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// >>> priority_pin_crossbar_io.sv
// Purpose: Port pin crossbar with GPIO latches, output modes and pull-ups.
// Assumes: Configuration and peripheral signals are on clk_sys; pins are not.
// Notes:   Config is registered once, the map once more, pin drive once more.
`timescale 1ns/1ns
module priority_pin_crossbar_io (
  input  wire logic                                clk_sys,
  input  wire logic                                rstn,
  input  wire pin_xbar_pkg::xbar_cfg_t             cfg,
  input  wire logic                                byte_wr,
  input  wire logic                                bit_wr,
  input  wire logic [2:0]                          wr_port,
  input  wire logic [2:0]                          wr_bit,
  input  wire logic [pin_xbar_pkg::PORT_W-1:0]     wr_data,
  input  wire logic                                rd_req,
  input  wire logic                                rd_rmw,
  input  wire logic [2:0]                          rd_port,
  output logic      [pin_xbar_pkg::PORT_W-1:0]     rd_data_r,
  output logic                                     rd_valid_r,
  input  wire logic [pin_xbar_pkg::NUM_SIGS-1:0]   periph_out,
  input  wire logic [pin_xbar_pkg::NUM_SIGS-1:0]   periph_drive,
  output logic      [pin_xbar_pkg::NUM_SIGS-1:0]   periph_in_r,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0]   pin_in,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0]   pin_out_r,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0]   pin_oe_n_r,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0]   pin_pullup_r,
  input  wire logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_pin_in,
  input  wire logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_output_mode,
  input  wire logic [pin_xbar_pkg::NUM_UPPER_PORTS-1:0] emi_active,
  input  wire logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] emi_out,
  input  wire logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] emi_drive,
  output logic      [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_pin_out_r,
  output logic      [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_pin_oe_n_r
);

  // ******************************************************************
  // Reset release and pin synchronisers
  // ******************************************************************
  logic                                    rst_s1_r;
  logic                                    rst_n_sync;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       pin_level;
  logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_level;

  // Releases the asynchronous reset through two flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_n_sync <= rst_s1_r;
    end
  end

  pin_sync #(.W(pin_xbar_pkg::NUM_PINS)) u_lower_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_sync),
    .d       (pin_in),
    .q       (pin_level)
  );

  pin_sync #(.W(pin_xbar_pkg::NUM_UPPER_PINS)) u_upper_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_sync),
    .d       (upper_pin_in),
    .q       (upper_level)
  );

  // ******************************************************************
  // Configuration, latches and crossbar map state
  // ******************************************************************
  pin_xbar_pkg::xbar_cfg_t                 cfg_r;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       lower_latch_r;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       lower_latch_nxt;
  logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_latch_r;
  logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_latch_nxt;
  logic [pin_xbar_pkg::SIG_W-1:0]          map_r   [pin_xbar_pkg::NUM_PINS];
  logic [pin_xbar_pkg::SIG_W-1:0]          map_nxt [pin_xbar_pkg::NUM_PINS];
  logic [pin_xbar_pkg::NUM_SIGS-1:0]       sig_en;

  // Byte writes reach any port; bit writes reach only the lower ports.
  always_comb begin
    lower_latch_nxt = lower_latch_r;
    upper_latch_nxt = upper_latch_r;
    if (byte_wr) begin
      if (wr_port < pin_xbar_pkg::FIRST_UPPER_PORT) begin
        lower_latch_nxt[{wr_port[1:0], 3'h0} +: 8] = wr_data;
      end else begin
        upper_latch_nxt[{wr_port[1:0], 3'h0} +: 8] = wr_data;
      end
    end
    if (bit_wr && (wr_port < pin_xbar_pkg::FIRST_UPPER_PORT)) begin
      lower_latch_nxt[{wr_port[1:0], wr_bit}] = wr_data[0];
    end
  end

  // Per-signal enables; each peripheral's signals share one enable, with NSS also gated by spi_four_wire.
  always_comb begin
    sig_en = '0;
    sig_en[pin_xbar_pkg::SIG_TX0]  = cfg_r.first_serial_port_pin_enable;
    sig_en[pin_xbar_pkg::SIG_RX0]  = cfg_r.first_serial_port_pin_enable;
    sig_en[pin_xbar_pkg::SIG_SDA]  = cfg_r.smbus_pin_enable;
    sig_en[pin_xbar_pkg::SIG_SCL]  = cfg_r.smbus_pin_enable;
    sig_en[pin_xbar_pkg::SIG_SCK]  = cfg_r.spi_pin_enable;
    sig_en[pin_xbar_pkg::SIG_MISO] = cfg_r.spi_pin_enable;
    sig_en[pin_xbar_pkg::SIG_MOSI] = cfg_r.spi_pin_enable;
    sig_en[pin_xbar_pkg::SIG_NSS]  = cfg_r.spi_pin_enable & cfg_r.spi_four_wire;
    sig_en[pin_xbar_pkg::SIG_TX1]  = cfg_r.second_serial_port_pin_enable;
    sig_en[pin_xbar_pkg::SIG_RX1]  = cfg_r.second_serial_port_pin_enable;
    sig_en[pin_xbar_pkg::SIG_CNV]  = cfg_r.converter_b_start_enable;
  end

  // Walks the pins upward, giving each digital pin the next enabled signal.
  always_comb begin
    int          next_sig;
    logic        found;
    logic [3:0]  sel;
    next_sig = 0;
    found    = 1'b0;
    sel      = pin_xbar_pkg::SIG_NONE;
    for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
      map_nxt[p] = pin_xbar_pkg::SIG_NONE;
      if (cfg_r.port_input_mode_reg[p]) begin
        found = 1'b0;
        sel   = pin_xbar_pkg::SIG_NONE;
        for (int s = 0; s < pin_xbar_pkg::NUM_SIGS; s++) begin
          if (!found && (s >= next_sig) && sig_en[s]) begin
            found = 1'b1;
            sel   = 4'(s);
          end
        end
        if (found) begin
          map_nxt[p] = sel;
          next_sig   = int'(sel) + 1;
        end
      end
    end
  end

  // Registers configuration, latches and the freshly computed map.
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cfg_r         <= pin_xbar_pkg::CFG_RESET;
      lower_latch_r <= pin_xbar_pkg::LATCH_RESET;
      upper_latch_r <= pin_xbar_pkg::LATCH_RESET;
      for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
        map_r[p] <= pin_xbar_pkg::SIG_NONE;
      end
    end else begin
      cfg_r         <= cfg;
      lower_latch_r <= lower_latch_nxt;
      upper_latch_r <= upper_latch_nxt;
      for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
        map_r[p] <= map_nxt[p];
      end
    end
  end

  // ******************************************************************
  // Pin drive, pull-ups, peripheral inputs and reads
  // ******************************************************************
  logic [pin_xbar_pkg::NUM_PINS-1:0]       pin_out_nxt;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       pin_oe_n_nxt;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       pin_pullup_nxt;
  logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_out_nxt;
  logic [pin_xbar_pkg::NUM_UPPER_PINS-1:0] upper_oe_n_nxt;
  logic [pin_xbar_pkg::NUM_SIGS-1:0]       periph_in_nxt;
  logic [pin_xbar_pkg::PORT_W-1:0]         rd_data_nxt;
  logic [pin_xbar_pkg::NUM_PINS-1:0]       lower_read_level;

  // Input-only signals never drive their pin.
  function automatic logic sig_in_only(input logic [3:0] s, input logic m0a, input logic m0b);
    sig_in_only = (s == pin_xbar_pkg::SIG_CNV) ||
                  ((s == pin_xbar_pkg::SIG_RX0) && !m0a) ||
                  ((s == pin_xbar_pkg::SIG_RX1) && !m0b);
  endfunction

  // Signals that are always open-drain whatever the mode bit says.
  function automatic logic sig_forced_od(input logic [3:0] s, input logic m0a, input logic m0b);
    sig_forced_od = (s == pin_xbar_pkg::SIG_SDA) || (s == pin_xbar_pkg::SIG_SCL) ||
                    ((s == pin_xbar_pkg::SIG_RX0) && m0a) ||
                    ((s == pin_xbar_pkg::SIG_RX1) && m0b);
  endfunction

  // Works out value, enable and pull-up for each lower pin.
  always_comb begin
    logic v;
    logic drv;
    logic od;
    v   = 1'b1;
    drv = 1'b0;
    od  = 1'b1;
    for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
      if (map_r[p] != pin_xbar_pkg::SIG_NONE) begin
        v   = periph_out[map_r[p]];
        drv = periph_drive[map_r[p]] &&
              !sig_in_only(map_r[p], cfg_r.first_serial_mode0, cfg_r.second_serial_mode0);
        od  = sig_forced_od(map_r[p], cfg_r.first_serial_mode0, cfg_r.second_serial_mode0) ||
              !cfg_r.port_output_mode_reg[p];
      end else begin
        v   = lower_latch_r[p];
        drv = 1'b1;
        od  = !cfg_r.port_output_mode_reg[p];
      end
      drv = drv && cfg_r.crossbar_global_enable;
      pin_out_nxt[p]  = 1'b0;
      pin_oe_n_nxt[p] = 1'b1;
      if (drv && od) begin
        pin_oe_n_nxt[p] = v;
      end else if (drv) begin
        pin_out_nxt[p]  = v;
        pin_oe_n_nxt[p] = 1'b0;
      end
      pin_pullup_nxt[p] = !cfg_r.global_pullup_disable && cfg_r.port_input_mode_reg[p] &&
                          !(!pin_oe_n_nxt[p] && !pin_out_nxt[p]);
    end
  end

  // Upper pins follow the memory interface while it owns the port.
  always_comb begin
    logic v;
    logic drv;
    v   = 1'b1;
    drv = 1'b0;
    for (int i = 0; i < pin_xbar_pkg::NUM_UPPER_PINS; i++) begin
      if (emi_active[i / pin_xbar_pkg::PORT_W]) begin
        v   = emi_out[i];
        drv = emi_drive[i];
      end else begin
        v   = upper_latch_r[i];
        drv = 1'b1;
      end
      upper_out_nxt[i]  = 1'b0;
      upper_oe_n_nxt[i] = 1'b1;
      if (drv && !upper_output_mode[i]) begin
        upper_oe_n_nxt[i] = v;
      end else if (drv) begin
        upper_out_nxt[i]  = v;
        upper_oe_n_nxt[i] = 1'b0;
      end
    end
  end

  // Routes each mapped pin level back to its peripheral; unmapped idle high.
  always_comb begin
    for (int s = 0; s < pin_xbar_pkg::NUM_SIGS; s++) begin
      periph_in_nxt[s] = 1'b1;
      for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
        if (map_r[p] == 4'(s)) begin
          periph_in_nxt[s] = pin_level[p];
        end
      end
    end
  end

  // Reads return pin levels, or latch contents for read-modify-write.
  always_comb begin
    lower_read_level = pin_level & cfg_r.port_input_mode_reg;
    rd_data_nxt      = rd_data_r;
    if (rd_req) begin
      if (rd_port < pin_xbar_pkg::FIRST_UPPER_PORT) begin
        rd_data_nxt = rd_rmw ? lower_latch_r[{rd_port[1:0], 3'h0} +: 8]
                             : lower_read_level[{rd_port[1:0], 3'h0} +: 8];
      end else begin
        rd_data_nxt = rd_rmw ? upper_latch_r[{rd_port[1:0], 3'h0} +: 8]
                             : upper_level[{rd_port[1:0], 3'h0} +: 8];
      end
    end
  end

  // Registers every output so that pins change only on the clock.
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_out_r        <= '0;
      pin_oe_n_r       <= '1;
      pin_pullup_r     <= '1;
      upper_pin_out_r  <= '0;
      upper_pin_oe_n_r <= '1;
      periph_in_r      <= '1;
      rd_data_r        <= pin_xbar_pkg::RD_DATA_RESET;
      rd_valid_r       <= 1'b0;
    end else begin
      pin_out_r        <= pin_out_nxt;
      pin_oe_n_r       <= pin_oe_n_nxt;
      pin_pullup_r     <= pin_pullup_nxt;
      upper_pin_out_r  <= upper_out_nxt;
      upper_pin_oe_n_r <= upper_oe_n_nxt;
      periph_in_r      <= periph_in_nxt;
      rd_data_r        <= rd_data_nxt;
      rd_valid_r       <= rd_req;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [pin_xbar_pkg::NUM_PINS-1:0] a_in_only;
  logic [pin_xbar_pkg::NUM_PINS-1:0] a_forced;
  logic [pin_xbar_pkg::NUM_PINS-1:0] a_gpio_pp;
  logic [pin_xbar_pkg::NUM_PINS-1:0] a_mapped;
  logic [pin_xbar_pkg::NUM_SIGS-1:0] a_has;

  // Summarises the current map for the checks below.
  always_comb begin
    a_has = '0;
    for (int p = 0; p < pin_xbar_pkg::NUM_PINS; p++) begin
      a_mapped[p]  = map_r[p] != pin_xbar_pkg::SIG_NONE;
      a_in_only[p] = a_mapped[p] &&
                     sig_in_only(map_r[p], cfg_r.first_serial_mode0, cfg_r.second_serial_mode0);
      a_forced[p]  = a_mapped[p] &&
                     sig_forced_od(map_r[p], cfg_r.first_serial_mode0, cfg_r.second_serial_mode0);
      a_gpio_pp[p] = !a_mapped[p] && cfg_r.crossbar_global_enable &&
                     cfg_r.port_output_mode_reg[p];
      if (a_mapped[p]) begin
        a_has[map_r[p]] = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_sync);

  xbar_off_a: assert property (!cfg_r.crossbar_global_enable |=> (&pin_oe_n_r))
    else $error("lower pin driven while crossbar disabled");
  first_serial_port_place_a: assert property ($past(cfg_r.first_serial_port_pin_enable &&
      (&cfg_r.port_input_mode_reg[1:0])) |->
      (map_r[0] == pin_xbar_pkg::SIG_TX0) && (map_r[1] == pin_xbar_pkg::SIG_RX0))
    else $error("first serial port not on port zero bits zero and one");
  input_pin_off_a: assert property (($past(a_in_only) & ~pin_oe_n_r) == '0)
    else $error("input signal pin has its driver on");
  forced_od_a: assert property (($past(a_forced) & ~pin_oe_n_r & pin_out_r) == '0)
    else $error("forced open-drain pin driven high");
  gpio_pp_a: assert property ((($past(a_gpio_pp) & (pin_out_r ^ $past(lower_latch_r))) |
      ($past(a_gpio_pp) & pin_oe_n_r)) == '0)
    else $error("push-pull GPIO pin does not follow its latch");
  pairs_a: assert property ((a_has[pin_xbar_pkg::SIG_TX0] == a_has[pin_xbar_pkg::SIG_RX0]) &&
      (a_has[pin_xbar_pkg::SIG_SDA] == a_has[pin_xbar_pkg::SIG_SCL]) &&
      (a_has[pin_xbar_pkg::SIG_TX1] == a_has[pin_xbar_pkg::SIG_RX1]))
    else $error("peripheral signals mapped apart");
  spi_count_a: assert property ((a_has[pin_xbar_pkg::SIG_MOSI] == $past(cfg_r.spi_pin_enable)) &&
      (a_has[pin_xbar_pkg::SIG_NSS] == $past(cfg_r.spi_pin_enable && cfg_r.spi_four_wire)))
    else $error("wrong number of SPI pins mapped");
  analog_skip_a: assert property ((a_mapped & ~$past(cfg_r.port_input_mode_reg)) == '0)
    else $error("analog pin was allocated");
  rmw_read_a: assert property (rd_req && rd_rmw && (rd_port < 3'h4) |=>
      rd_valid_r && (rd_data_r == $past(lower_latch_r[{rd_port[1:0], 3'h0} +: 8])))
    else $error("read-modify-write read did not return latch");
  pin_read_a: assert property (rd_req && !rd_rmw && (rd_port < 3'h4) |=>
      rd_data_r == $past(lower_read_level[{rd_port[1:0], 3'h0} +: 8]))
    else $error("normal read did not return pin level");
  pullup_off_a: assert property (cfg_r.global_pullup_disable |=> (pin_pullup_r == '0))
    else $error("pull-up on while globally disabled");

  first_serial_port_map_c: cover property (a_has[pin_xbar_pkg::SIG_TX0] && cfg_r.crossbar_global_enable);
  spi_four_c:  cover property (a_has[pin_xbar_pkg::SIG_NSS] && a_has[pin_xbar_pkg::SIG_TX1]);
  rmw_read_c:  cover property (rd_req && rd_rmw);
  skip_c:      cover property (a_has[pin_xbar_pkg::SIG_CNV] && !(&cfg_r.port_input_mode_reg));

endmodule

// >>> ext_pins.sv
// Purpose: Board model of the lower port pins.
// Assumes: A device driver beats the board; the board beats a pull-up.
// Notes:   A pin with no driver and no pull-up shows the inverse of pin_out.
`timescale 1ns/1ns
module ext_pins (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe_n,
  input  wire logic [31:0] pin_pullup,
  input  wire logic [31:0] ext_lvl,
  input  wire logic [31:0] ext_en,
  output logic      [31:0] pin_lvl
);
  // Resolve each wire from device drive, board drive and pull-up.
  always_comb begin
    pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_lvl)
            | (pin_oe_n & ~ext_en & (pin_pullup | ~pin_out));
  end
endmodule

// >>> test_priority_pin_crossbar_io.sv
// Purpose: Self-checking bench for the priority pin crossbar.
// Assumes: Settle times follow the hand-over latencies.
// Notes:   Reset, GPIO rows, crossbar cases, a mid-run reset, then the upper port.
`timescale 1ns/1ns
module test_priority_pin_crossbar_io;
  typedef struct {logic [7:0] d; logic pp; logic [7:0] oe_n; logic [7:0] q;} row_t;
  pin_xbar_pkg::xbar_cfg_t cfg;
  logic        clk_sys, rstn, byte_wr, bit_wr, rd_req, rd_rmw, rd_valid_r;
  logic [2:0]  wr_port, wr_bit, rd_port;
  logic [7:0]  wr_data, rd_data_r, v;
  logic [10:0] periph_out, periph_drive, periph_in_r;
  logic [31:0] pin_in, pin_out_r, pin_oe_n_r, pin_pullup_r, ext_lvl, ext_en;
  logic [31:0] up_mode, up_out, up_oe_n, emi_o, emi_d;
  logic [3:0]  emi_act;
  int          err_total = 0, n_compared = 0, cyc = 0;
  row_t        rows [4] = '{'{8'hA5, 1'b1, 8'h00, 8'hA5}, '{8'hA5, 1'b0, 8'hA5, 8'h00},
                            '{8'h00, 1'b0, 8'h00, 8'h00}, '{8'hFF, 1'b1, 8'h00, 8'hFF}};
  priority_pin_crossbar_io dut (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .byte_wr(byte_wr),
    .bit_wr(bit_wr), .wr_port(wr_port), .wr_bit(wr_bit), .wr_data(wr_data), .rd_req(rd_req),
    .rd_rmw(rd_rmw), .rd_port(rd_port), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .periph_out(periph_out), .periph_drive(periph_drive), .periph_in_r(periph_in_r),
    .pin_in(pin_in), .pin_out_r(pin_out_r), .pin_oe_n_r(pin_oe_n_r),
    .pin_pullup_r(pin_pullup_r), .upper_pin_in(up_out), .upper_output_mode(up_mode),
    .emi_active(emi_act), .emi_out(emi_o), .emi_drive(emi_d), .upper_pin_out_r(up_out),
    .upper_pin_oe_n_r(up_oe_n));
  ext_pins board (.pin_out(pin_out_r), .pin_oe_n(pin_oe_n_r), .pin_pullup(pin_pullup_r),
    .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_lvl(pin_in));
  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Byte write, or bit write of bit three when b is set.
  task automatic wr(input logic [2:0] p, input logic [7:0] d, input logic b);
    @(posedge clk_sys);
    byte_wr <= !b;
    bit_wr <= b;
    wr_port <= p;
    wr_bit <= 3'h3;
    wr_data <= d;
    @(posedge clk_sys);
    byte_wr <= 1'b0;
    bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic m, output logic [7:0] d);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_port <= p;
    rd_rmw <= m;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    #1;
    chk(rd_valid_r, 1'b1);
    d = rd_data_r;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: reset, GPIO rows, then crossbar cases.
  initial begin
    cfg = pin_xbar_pkg::CFG_RESET;
    {rstn, byte_wr, bit_wr, rd_req, rd_rmw, wr_port, wr_bit, rd_port, wr_data} = '0;
    periph_out = '0;
    periph_drive = 11'h103;
    {up_mode, emi_act, emi_o} = '0;
    emi_d = '1;
    ext_lvl = '0;
    ext_en = 32'h00000002;
    wt(1);
    chk(pin_oe_n_r, '1);
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    wt(3);
    wr(3'h2, 8'h00, 1'b0);
    wt(4);
    chk(pin_oe_n_r, '1);
    @(posedge clk_sys);
    cfg.crossbar_global_enable <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk_sys);
      cfg.port_output_mode_reg[15:8] <= {8{rows[i].pp}};
      wr(3'h1, rows[i].d, 1'b0);
      wt(4);
      chk(pin_oe_n_r[15:8], rows[i].oe_n);
      chk(pin_out_r[15:8], rows[i].q);
      rd(3'h1, 1'b1, v);
      chk(v, rows[i].d);
      wt(4);
      rd(3'h1, 1'b0, v);
      chk(v, rows[i].d);
    end
    wr(3'h1, 8'h00, 1'b1);
    wt(4);
    chk(pin_out_r[15:8], 8'hF7);
    @(posedge clk_sys);
    cfg.first_serial_port_pin_enable <= 1'b1;
    cfg.port_output_mode_reg[7:0] <= 8'h01;
    wr(3'h0, 8'hFF, 1'b0);
    wt(8);
    chk(pin_oe_n_r[1:0], 2'b10);
    chk(pin_out_r[0], 1'b0);
    chk(pin_pullup_r[7:0], 8'hFE);
    chk(periph_in_r[1], 1'b0);
    rd(3'h0, 1'b0, v);
    chk(v, 8'hFC);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_sys);
      cfg.spi_pin_enable <= 1'b1;
      cfg.spi_four_wire <= w[0];
      cfg.second_serial_port_pin_enable <= 1'b1;
      wt(8);
      chk(pin_oe_n_r[7:5], w[0] ? 3'b101 : 3'b110);
    end
    // Two-wire lines stay open-drain; a push-pull peripheral pin drives high.
    @(posedge clk_sys);
    cfg.smbus_pin_enable <= 1'b1;
    cfg.port_output_mode_reg[7:0] <= 8'hFF;
    periph_out <= 11'h10C;
    periph_drive <= 11'h10F;
    wt(8);
    chk(pin_oe_n_r[3:2], 2'b11);
    chk(pin_out_r[8], 1'b1);
    @(posedge clk_sys);
    cfg.crossbar_global_enable <= 1'b0;
    wt(5);
    chk(pin_oe_n_r, '1);
    chk(pin_pullup_r, '1);
    @(posedge clk_sys);
    cfg.global_pullup_disable <= 1'b1;
    wt(3);
    chk(pin_pullup_r, '0);
    // Mid-run reset restores pull-ups and latches, then config takes over again.
    @(posedge clk_sys);
    rstn <= 1'b0;
    wt(1);
    chk(pin_pullup_r, '1);
    @(posedge clk_sys);
    rstn <= 1'b1;
    wt(5);
    chk(pin_pullup_r, '0);
    rd(3'h2, 1'b1, v);
    chk(v, 8'hFF);
    // Upper port: byte GPIO, bit writes ignored, then the memory interface owns it.
    @(posedge clk_sys);
    up_mode <= 32'h000000FF;
    wr(3'h4, 8'h3C, 1'b0);
    wr(3'h4, 8'h00, 1'b1);
    wt(6);
    chk(up_oe_n[7:0], 8'h00);
    chk(up_out[7:0], 8'h3C);
    rd(3'h4, 1'b0, v);
    chk(v, 8'h3C);
    @(posedge clk_sys);
    emi_act <= 4'h1;
    emi_o <= 32'h0000005A;
    wt(3);
    chk(up_out[7:0], 8'h5A);
    print_verdict();
  end
endmodule
